/* File: hw/cbt_bus_seq.sv */
// cpu bus interface sequencer: translation state, float, abort and bus hold
module cbt_bus_seq
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // core bus cycle request
  input  wire logic        cyc_req,
  input  wire logic [1:0]  cyc_kind,
  input  wire logic        cyc_write,
  input  wire logic [3:0]  cyc_status,
  input  wire logic [23:0] cyc_addr,
  input  wire logic [31:0] cyc_wdata,
  input  wire logic [3:0]  cyc_be,
  output logic             cyc_done,
  output logic             cyc_aborted,
  output logic [31:0]      cyc_rdata,
  // core instruction side
  input  wire logic [31:0] insn_addr,
  input  wire logic        queue_empty,
  input  wire logic        mmu_insn,
  input  wire logic        set_configuration_instruction_strobe,
  input  wire logic        set_configuration_instruction_mmu,
  output logic             undef_trap,
  output logic             abort_trap,
  output logic [31:0]      abort_ret_addr,
  output logic             hipri_abort,
  output logic             prefetch_halted,
  output logic             core_stall,
  output logic             translate_mode,
  // multiplexed address/data and upper data
  input  wire logic [23:0] address_data_lines_i,
  output logic [23:0]      address_data_lines_o,
  output logic             address_data_lines_oe,
  input  wire logic [7:0]  upper_data_lines_i,
  output logic [7:0]       upper_data_lines_o,
  output logic             upper_data_lines_oe,
  // strobes, direction, byte enables, status
  output logic             address_strobe_n_o,
  output logic             address_strobe_oe,
  output logic             data_direction_o,
  output logic             data_direction_oe,
  output logic [3:0]       byte_enables_n_o,
  output logic             byte_enables_oe,
  output logic [3:0]       bus_status_o,
  // shared strobe/float pin and strap/coprocessor strobe pin
  input  wire logic        strobe_or_float_pin_i,
  output logic             strobe_or_float_pin_o,
  output logic             strobe_or_float_pin_oe,
  input  wire logic        translation_strap_pin_i,
  output logic             translation_strap_pin_o,
  output logic             translation_strap_pin_oe,
  // reset/abort and bus hold pins
  input  wire logic        reset_abort_pin_n,
  input  wire logic        bus_request_n,
  output logic             bus_grant_out_n
);
  typedef struct packed {
    cbt_state_e  st;
    logic        strap_low;
    logic        mmu_valid;
    logic        abort_pend;
    logic        abortable;
    logic        pf_halted;
    logic [1:0]  kind;
    logic        write;
    logic [3:0]  status;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        done;
    logic        aborted;
    logic        abt_trap;
    logic [31:0] ret_addr;
    logic        hipri;
    logic        undef;
  } cbt_seq_s;

  cbt_seq_s s_q;
  cbt_seq_s s_d;

  logic [3:0] pins_sync;
  logic       float_raw_n;
  logic       strap_sync;
  logic       hold_req;
  logic       float_cmd;
  logic       abort_hit;

  cbt_rstab_if rif ();

  // all control pins are asynchronous to ref_clk
  cbt_sync #(
    .W (4)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({strobe_or_float_pin_i, translation_strap_pin_i,
               bus_request_n, reset_abort_pin_n}),
    .q       (pins_sync)
  );

  assign float_raw_n = pins_sync[3];
  assign strap_sync  = pins_sync[2];
  assign hold_req    = !pins_sync[1];
  assign rif.pin_low = !pins_sync[0];

  cbt_rstab_class u_rstab_class (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .rif     (rif)
  );

  // float command only exists in translation mode
  assign float_cmd = s_q.strap_low && !float_raw_n;
  // abort counts only if the clock before the abort pulse was in the translation or a float state
  assign abort_hit = rif.abort_pls && s_q.abortable;

  // next-state logic for the whole sequencer
  always_comb
  begin
    s_d           = s_q;
    s_d.done      = 1'b0;
    s_d.aborted   = 1'b0;
    s_d.abt_trap  = 1'b0;
    s_d.hipri     = 1'b0;
    s_d.undef     = 1'b0;
    s_d.abortable = (s_q.st == ST_TMMU) || (s_q.st == ST_TF);
    // an abort outside the windows is a non-recoverable high priority event
    if (rif.abort_pls && !s_q.abortable)
      s_d.hipri = 1'b1;
    // configuration opens the memory-management instruction set
    if (set_configuration_instruction_strobe)
      s_d.mmu_valid = set_configuration_instruction_mmu;
    if (mmu_insn && !s_q.mmu_valid)
      s_d.undef = 1'b1;
    // halted prefetch only traps once the queue really runs dry
    if (s_q.pf_halted && queue_empty)
    begin
      s_d.pf_halted = 1'b0;
      s_d.abt_trap  = 1'b1;
      s_d.ret_addr  = insn_addr;
    end
    case (s_q.st)
      ST_IDLE:
      begin
        // a committed cycle beats a hold request seen in the same clock
        if (cyc_req)
        begin
          s_d.kind   = cyc_kind;
          s_d.write  = cyc_write;
          s_d.addr   = cyc_addr;
          s_d.wdata  = cyc_wdata;
          s_d.be     = cyc_be;
          s_d.status = (cyc_kind == KIND_RMW) ? STATUS_RMW : cyc_status;
          s_d.st     = (cyc_kind == KIND_COPROC) ? ST_CT1 : ST_T1;
        end
        else if (hold_req)
          s_d.st = ST_HOLD;
      end
      ST_T1:
        s_d.st = s_q.strap_low ? ST_TMMU : ST_T2;
      ST_TMMU:
        s_d.st = float_cmd ? ST_TF : ST_T2;
      ST_TF:
      begin
        // abort is remembered but acted on only when float drops
        if (abort_hit)
          s_d.abort_pend = 1'b1;
        if (!float_cmd)
          s_d.st = ST_T2;
      end
      ST_T2:
      begin
        if (s_q.abort_pend || abort_hit)
        begin
          s_d.st         = ST_IDLE;
          s_d.abort_pend = 1'b0;
          s_d.done       = 1'b1;
          s_d.aborted    = 1'b1;
          if (s_q.kind == KIND_PREFETCH)
            s_d.pf_halted = 1'b1;
          else
          begin
            s_d.abt_trap = 1'b1;
            s_d.ret_addr = insn_addr;
          end
        end
        else
          s_d.st = ST_T3;
      end
      ST_T3:
        s_d.st = ST_T4;
      ST_T4:
      begin
        s_d.rdata = {upper_data_lines_i, address_data_lines_i};
        s_d.done  = 1'b1;
        s_d.st    = hold_req ? ST_HOLD : ST_IDLE;
      end
      ST_CT1:
        s_d.st = ST_CT4;
      ST_CT4:
      begin
        s_d.rdata = {16'h0000, address_data_lines_i[15:0]};
        s_d.done  = 1'b1;
        s_d.st    = hold_req ? ST_HOLD : ST_IDLE;
      end
      ST_HOLD:
        if (!hold_req)
          s_d.st = ST_IDLE;
      default:
        s_d.st = ST_IDLE;
    endcase
    // a long low on the reset/abort pin resets everything but the strap
    if (rif.reset_act)
    begin
      s_d           = '0;
      s_d.st        = ST_IDLE;
      s_d.strap_low = s_q.strap_low;
      s_d.mmu_valid = MMU_VALID_RST;
    end
    // strap is taken as the reset pulse ends and then frozen
    if (rif.reset_rel)
      s_d.strap_low = !strap_sync;
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_q           <= '0;
      s_q.st        <= ST_IDLE;
      s_q.strap_low <= STRAP_LOW_RST;
      s_q.mmu_valid <= MMU_VALID_RST;
    end
    else
      s_q <= s_d;
  end

  // core-facing outputs
  assign cyc_done        = s_q.done;
  assign cyc_aborted     = s_q.aborted;
  assign cyc_rdata       = s_q.rdata;
  assign undef_trap      = s_q.undef;
  assign abort_trap      = s_q.abt_trap;
  assign abort_ret_addr  = s_q.ret_addr;
  assign hipri_abort     = s_q.hipri;
  assign prefetch_halted = s_q.pf_halted;
  assign core_stall      = (s_q.st == ST_TF);
  assign translate_mode  = s_q.strap_low;

  // pin drive; address/data and upper data lines float while held or floating
  always_comb
  begin
    address_data_lines_o  = s_q.addr;
    address_data_lines_oe = 1'b0;
    upper_data_lines_o    = s_q.wdata[31:24];
    upper_data_lines_oe   = 1'b0;
    case (s_q.st)
      ST_T1:
        address_data_lines_oe = 1'b1;
      ST_T2, ST_T3, ST_T4:
      begin
        // address already latched outside, so the lines now carry data
        address_data_lines_o  = s_q.wdata[23:0];
        address_data_lines_oe = s_q.write;
        upper_data_lines_oe   = s_q.write;
      end
      ST_CT1, ST_CT4:
      begin
        address_data_lines_o  = {8'h00, s_q.wdata[15:0]};
        address_data_lines_oe = s_q.write;
      end
      default:
        address_data_lines_oe = 1'b0;
    endcase
  end

  // strobes and enables are released only while held; direction is also released in the float state
  assign address_strobe_n_o = (s_q.st != ST_T1);
  assign address_strobe_oe  = (s_q.st != ST_HOLD);
  assign data_direction_o   = !s_q.write;
  assign data_direction_oe  = (s_q.st != ST_HOLD) && (s_q.st != ST_TF);
  assign byte_enables_n_o   = ~s_q.be;
  assign byte_enables_oe    = (s_q.st != ST_HOLD);
  assign bus_status_o       = s_q.status;
  assign bus_grant_out_n    = (s_q.st != ST_HOLD);

  // data strobe only without translation; otherwise the pin is an input
  assign strobe_or_float_pin_o  = !((s_q.st == ST_T2) || (s_q.st == ST_T3));
  assign strobe_or_float_pin_oe = !s_q.strap_low && (s_q.st != ST_HOLD);

  // coprocessor strobe is low through t1 of a coprocessor cycle
  assign translation_strap_pin_o  = (s_q.st != ST_CT1);
  assign translation_strap_pin_oe = (s_q.st == ST_CT1) || (s_q.st == ST_CT4);

  // strap mode is only ever changed by a reset release
  property p_strap_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !rif.reset_rel |=> $stable(s_q.strap_low);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed outside reset");

  property p_tmmu_added;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_T1 && s_q.strap_low && !rif.reset_act |=> s_q.st == ST_TMMU;
  endproperty
  a_tmmu_added: assert property (p_tmmu_added) else $error("translation state missing");

  property p_no_tmmu;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_T1 && !s_q.strap_low && !rif.reset_act |=> s_q.st == ST_T2;
  endproperty
  a_no_tmmu: assert property (p_no_tmmu) else $error("translation state not expected");

  property p_float_input;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.strap_low |-> !strobe_or_float_pin_oe;
  endproperty
  a_float_input: assert property (p_float_input) else $error("float pin driven");

  property p_undef;
    @(posedge ref_clk) disable iff (!rst_n)
      mmu_insn && !s_q.mmu_valid && !rif.reset_act |=> undef_trap;
  endproperty
  a_undef: assert property (p_undef) else $error("mmu instruction not trapped");

  property p_float_lines;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_TF |-> !address_data_lines_oe && !upper_data_lines_oe
                          && !data_direction_oe && core_stall;
  endproperty
  a_float_lines: assert property (p_float_lines) else $error("float state drives bus");

  sequence s_tmmu_float;
    s_q.st == ST_TMMU && float_cmd && !rif.reset_act;
  endsequence
  sequence s_float_then_t2;
    s_q.st == ST_TF ##[1:8] s_q.st == ST_T2;
  endsequence
  property p_float_enter;
    @(posedge ref_clk) disable iff (!rst_n)
      s_tmmu_float |=> s_q.st == ST_TF;
  endproperty
  a_float_enter: assert property (p_float_enter) else $error("float not entered");

  property p_abort_ends;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_TF && abort_hit && !float_cmd && !rif.reset_act
        |=> s_q.st == ST_T2 ##1 s_q.st == ST_IDLE && cyc_aborted;
  endproperty
  a_abort_ends: assert property (p_abort_ends) else $error("aborted cycle did not end");

  property p_hold_float;
    @(posedge ref_clk) disable iff (!rst_n)
      !bus_grant_out_n |-> !address_data_lines_oe && !address_strobe_oe
                           && !byte_enables_oe && !data_direction_oe;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("bus driven while granted");

  property p_idle_grant;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_IDLE && hold_req && !cyc_req && !rif.reset_act |=> !bus_grant_out_n;
  endproperty
  a_idle_grant: assert property (p_idle_grant) else $error("idle grant late");

  property p_release;
    @(posedge ref_clk) disable iff (!rst_n)
      !bus_grant_out_n && !hold_req |=> bus_grant_out_n;
  endproperty
  a_release: assert property (p_release) else $error("grant not dropped");

  property p_rmw_status;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_T1 && s_q.kind == KIND_RMW |-> bus_status_o == STATUS_RMW;
  endproperty
  a_rmw_status: assert property (p_rmw_status) else $error("rmw status missing");

  property p_coproc_strobe;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_CT1 |-> translation_strap_pin_oe && !translation_strap_pin_o
                           ##1 translation_strap_pin_oe && translation_strap_pin_o;
  endproperty
  a_coproc_strobe: assert property (p_coproc_strobe) else $error("coprocessor strobe wrong");

  property p_pf_abort;
    @(posedge ref_clk) disable iff (!rst_n)
      s_q.st == ST_T2 && s_q.abort_pend && s_q.kind == KIND_PREFETCH && !rif.reset_act
        |=> prefetch_halted && !abort_trap;
  endproperty
  a_pf_abort: assert property (p_pf_abort) else $error("prefetch abort trapped");

  property p_float_resume;
    @(posedge ref_clk) disable iff (!rst_n)
      s_float_then_t2 |=> s_q.st == ST_T3 || s_q.st == ST_IDLE;
  endproperty
  a_float_resume: assert property (p_float_resume) else $error("float exit wrong");
endmodule

/* File: pkg/cbt_pkg.sv */
// shared constants and types for the cpu bus translation, abort and hold sequencer
// Functional notes
// - strap level caught at reset release; bus timing mode held until next reset
// - strap low adds one translation state to every non-coprocessor bus cycle
// - strap low turns the shared strobe pin into a float command input
// - memory-management instructions trap as undefined until configuration declares them valid
// - translation state sits between T1 and T2 with address/data lines floated
// - T2 to T4 of a translated cycle match an untranslated cycle
// - upper address lines released after the address is latched, then carry data
// - float command during translation enters float idle states instead of T2
// - float states float address/data, upper data, direction and stall the instruction
// - reset/abort pin low one clock is abort, longer low is reset
// - abort in translation or float state goes T2 then idle, no access
// - aborted instruction takes abort vector with its own address as return
// - aborted prefetch halts prefetch; trap only when the queue runs empty
// - abort during float is acted upon only after float is released
// - read half of read-modify-write drives status 1011; translator aborts it
// - abort outside permitted windows raises a high priority abort
// - before grant, bus lines, strobes, direction and byte enables float; the code floats them in the same clock as the grant
// - master drops request; device then drops grant
// - idle bus grants in the cycle after the request is seen
// - request seen before T4 is granted in the clock after T4
// - committed new cycle defers the grant to that cycle's T4
// - strap pin drives the coprocessor data strobe during coprocessor cycles
package cbt_pkg;

  // bus sequencer states, gray along idle-t1-tmmu-t2-t3-t4
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_T1    = 4'h1,
    ST_TMMU  = 4'h3,
    ST_T2    = 4'h2,
    ST_T3    = 4'h6,
    ST_T4    = 4'h7,
    ST_TF    = 4'h5,
    ST_CT1   = 4'h4,
    ST_CT4   = 4'hc,
    ST_HOLD  = 4'hd
  } cbt_state_e;

  // bus cycle kinds requested by the core
  localparam logic [1:0] KIND_DATA     = 2'h0;
  localparam logic [1:0] KIND_PREFETCH = 2'h1;
  localparam logic [1:0] KIND_COPROC   = 2'h2;
  localparam logic [1:0] KIND_RMW      = 2'h3;

  // status code shown during the read half of read-modify-write
  localparam logic [3:0] STATUS_RMW    = 4'hb;

  // low-level length classification of the reset/abort pin, in clocks
  localparam logic [1:0] LOW_ABORT_CNT = 2'h1;
  localparam logic [1:0] LOW_RESET_CNT = 2'h2;

  // values after reset
  localparam logic       STRAP_LOW_RST = 1'b0;
  localparam logic       MMU_VALID_RST = 1'b0;

endpackage

/* File: pkg/cbt_rstab_if.sv */
// carrier between the sequencer and the reset/abort pulse classifier
interface cbt_rstab_if;
  logic pin_low;
  logic abort_pls;
  logic reset_act;
  logic reset_rel;

  modport classifier (input pin_low, output abort_pls, output reset_act, output reset_rel);
  modport sequencer  (output pin_low, input abort_pls, input reset_act, input reset_rel);
endinterface

/* File: hw/cbt_sync.sv */
// two-flop synchroniser for pin levels
module cbt_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } cbt_sync_s;

  cbt_sync_s s_q;
  cbt_sync_s s_d;

  // first stage feeds only the second stage
  always_comb
  begin
    s_d.meta = d;
    s_d.stab = s_q.meta;
  end

  // pins idle high, so reset to all ones
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_q <= '1;
    else
      s_q <= s_d;
  end

  assign q = s_q.stab;
endmodule

/* File: hw/cbt_rstab_class.sv */
// tells a one-clock abort pulse from a longer reset on the shared pin
module cbt_rstab_class
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // classified pin events
  cbt_rstab_if.classifier rif
);
  typedef struct packed {
    logic [1:0] low_cnt;
    logic       abort_pls;
    logic       reset_act;
    logic       reset_rel;
  } cbt_cls_s;

  cbt_cls_s s_q;
  cbt_cls_s s_d;

  // count low clocks, saturating; verdict given when the pin rises
  always_comb
  begin
    s_d = s_q;
    s_d.abort_pls = 1'b0;
    s_d.reset_rel = 1'b0;
    if (rif.pin_low)
    begin
      if (s_q.low_cnt != LOW_RESET_CNT)
        s_d.low_cnt = s_q.low_cnt + 2'h1;
      s_d.reset_act = (s_q.low_cnt != 2'h0); // second low clock means reset
    end
    else
    begin
      s_d.abort_pls = (s_q.low_cnt == LOW_ABORT_CNT);
      s_d.reset_rel = (s_q.low_cnt == LOW_RESET_CNT);
      s_d.low_cnt   = 2'h0;
      s_d.reset_act = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rif.abort_pls = s_q.abort_pls;
  assign rif.reset_act = s_q.reset_act;
  assign rif.reset_rel = s_q.reset_rel;

  // a single low clock gives exactly one abort pulse
  property p_abort_class;
    @(posedge ref_clk) disable iff (!rst_n)
      !rif.pin_low ##1 rif.pin_low ##1 !rif.pin_low |=> rif.abort_pls && !rif.reset_act;
  endproperty
  a_abort_class: assert property (p_abort_class) else $error("single low clock not abort");
endmodule

/* File: sim/cbt_far_model.sv */
// far-side model: address translator, abort source and bus-requesting master
module cbt_far_model (
  // clock
  input  wire logic        ref_clk,
  // commands from the bench
  input  wire logic        float_on,
  input  wire logic        abort_go,
  input  wire logic        hold_req,
  input  wire logic        strap_lvl,
  // device pin drivers
  input  wire logic [23:0] address_data_lines_o,
  input  wire logic        address_data_lines_oe,
  input  wire logic        strobe_or_float_pin_o,
  input  wire logic        strobe_or_float_pin_oe,
  input  wire logic        translation_strap_pin_o,
  input  wire logic        translation_strap_pin_oe,
  // resolved pin levels
  output logic [23:0]      address_data_lines_i,
  output logic [7:0]       upper_data_lines_i,
  output logic             strobe_or_float_pin_i,
  output logic             translation_strap_pin_i,
  output logic             reset_abort_pin_n,
  output logic             bus_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] pat_q = 24'h5a3c96;
  // released lines wander each clock so a stale value is never trusted
  always @(posedge ref_clk) pat_q <= pat_q + 24'h010101;
  assign address_data_lines_i = address_data_lines_oe ? address_data_lines_o : pat_q;
  assign upper_data_lines_i = ~pat_q[7:0];
  // float command held low only while more translation time is wanted
  assign strobe_or_float_pin_i = strobe_or_float_pin_oe ? strobe_or_float_pin_o : ~float_on;
  // strap pulled to its level unless the device drives its coprocessor strobe
  assign translation_strap_pin_i = translation_strap_pin_oe ? translation_strap_pin_o : strap_lvl;
  // abort pin simply follows abort_go from the bench; short lows are aborts, long lows are resets
  assign reset_abort_pin_n = ~abort_go;
  // master holds its request for as long as it owns the bus
  assign bus_request_n = ~hold_req;
endmodule

/* File: sim/tb.sv */
// self-checking bench for the bus translation, abort and hold sequencer
module tb
  import cbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic tr; logic [1:0] kind; int float_command; logic abort_vector; int lat;
                  logic [4:0] seen;} cbt_row_s;
  logic        ref_clk = 1'b0, rst_n = 1'b0, cyc_req = 1'b0, cyc_write = 1'b0;
  logic        queue_empty = 1'b0, mmu_insn = 1'b0, set_configuration_instruction_strobe = 1'b0, set_configuration_instruction_mmu = 1'b0;
  logic        float_on = 1'b0, abort_go = 1'b0, hold_req = 1'b0, strap_lvl = 1'b1;
  logic [1:0]  cyc_kind = KIND_DATA;
  logic [3:0]  cyc_status = 4'h8, cyc_be = 4'hf, byte_enables_n_o, bus_status_o;
  logic [23:0] cyc_addr = 24'h001234, address_data_lines_i, address_data_lines_o;
  logic [31:0] cyc_wdata = 32'h0badf00d, insn_addr = 32'h00004410, cyc_rdata, abort_ret_addr;
  logic [7:0]  upper_data_lines_i, upper_data_lines_o;
  logic        cyc_done, cyc_aborted, undef_trap, abort_trap, hipri_abort, prefetch_halted;
  logic        core_stall, translate_mode, address_data_lines_oe, upper_data_lines_oe;
  logic        address_strobe_n_o, address_strobe_oe, data_direction_o, data_direction_oe;
  logic        byte_enables_oe, strobe_or_float_pin_i, strobe_or_float_pin_o;
  logic        strobe_or_float_pin_oe, translation_strap_pin_i, translation_strap_pin_o;
  logic        translation_strap_pin_oe, reset_abort_pin_n, bus_request_n, bus_grant_out_n;
  int          err_total = 0, num_checks = 0, lat, n;
  logic [4:0]  seen;
  // seen bits: aborted, stalled, driving in translation state, rmw status, abort trap
  cbt_row_s    rows[10] = '{
    '{0, KIND_DATA, 0, 0, 5, 5'h00}, '{0, KIND_COPROC, 0, 0, 3, 5'h00},
    '{0, KIND_RMW, 0, 0, 5, 5'h02}, '{1, KIND_DATA, 0, 0, 6, 5'h00},
    '{1, KIND_COPROC, 0, 0, 3, 5'h00}, '{1, KIND_RMW, 0, 0, 6, 5'h02},
    '{1, KIND_PREFETCH, 0, 0, 6, 5'h00}, '{1, KIND_DATA, 3, 0, 11, 5'h08},
    '{1, KIND_DATA, 0, 1, 4, 5'h11}, '{1, KIND_PREFETCH, 3, 1, 9, 5'h18}};

  cbt_bus_seq   cbt_bus_seq_inst (.*);
  cbt_far_model cbt_far_model_inst (.*);

  always #12.5 ref_clk = ~ref_clk;

  // inputs always move the same small delay after the rising edge
  task automatic tick();
    @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a bound that runs out ends the run at once rather than hanging
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim)
    begin
      tick();
      k++;
    end
    chk(s, v);
    if (s !== v)
      give_verdict();
  endtask

  // long low on the shared pin with the strap low selects translation, then strap lifts
  task automatic pin_reset();
    strap_lvl = 1'b0;
    abort_go = 1'b1;
    repeat (4) tick();
    abort_go = 1'b0;
    repeat (8) tick();
    strap_lvl = 1'b1;
    repeat (4) tick();
    chk(translate_mode, 1'b1);
    chk(strobe_or_float_pin_oe, 1'b0);
  endtask

  // one core cycle; float held flt + 2 clocks into it; abort pin pulsed ahead of the take
  // when abt, since the synchroniser and the length check add about four clocks
  task automatic run_cyc(input logic [1:0] kind, input int float_command, input logic abort_vector,
                         output int lt, output logic [4:0] sn);
    lt = 0;
    sn = 5'h00;
    cyc_kind = kind;
    float_on = (float_command > 0);
    repeat (2) tick();
    abort_go = abort_vector;
    tick();
    abort_go = 1'b0;
    cyc_req = 1'b1;
    while (cyc_done !== 1'b1 && lt < 60)
    begin
      tick();
      lt++;
      cyc_req = 1'b0;
      if (lt == 1 && kind != KIND_COPROC)
        chk({address_strobe_n_o, address_data_lines_oe, byte_enables_n_o, address_data_lines_o},
            {1'b0, 1'b1, ~cyc_be, cyc_addr});
      if (lt == float_command + 2)
        float_on = 1'b0;
      if (lt == 2 && translate_mode === 1'b1 && kind != KIND_COPROC)
        sn[2] = address_data_lines_oe !== 1'b0;
      sn |= {cyc_aborted === 1'b1, core_stall === 1'b1, 1'b0,
             bus_status_o === STATUS_RMW, abort_trap === 1'b1};
    end
    wait_lvl(cyc_done, 1'b1, 1, n);
  endtask

  initial
  begin
    repeat (20) tick();
    rst_n = 1'b1;
    tick();
    chk(strobe_or_float_pin_oe, 1'b1);
    chk({translate_mode, bus_grant_out_n}, 2'b01);
    foreach (rows[i])
    begin
      if (rows[i].tr !== translate_mode)
        pin_reset();
      run_cyc(rows[i].kind, rows[i].float_command, rows[i].abort_vector, lat, seen);
      if (rows[i].lat > 0)
        chk(lat, rows[i].lat);
      chk(seen, rows[i].seen);
      if (rows[i].kind != KIND_COPROC && !rows[i].abort_vector)
        chk(cyc_rdata[31:24], {~cyc_rdata[7:0]});
    end
    chk(prefetch_halted, 1'b1);
    queue_empty = 1'b1;
    wait_lvl(abort_trap, 1'b1, 4, n);
    queue_empty = 1'b0;
    chk(abort_ret_addr, insn_addr);
    // mmu instructions trap until configuration declares them valid
    mmu_insn = 1'b1;
    tick();
    mmu_insn = 1'b0;
    chk(undef_trap, 1'b1);
    {set_configuration_instruction_strobe, set_configuration_instruction_mmu} = 2'b11;
    tick();
    {set_configuration_instruction_strobe, mmu_insn} = 2'b01;
    tick();
    mmu_insn = 1'b0;
    chk(undef_trap, 1'b0);
    // abort pulse with no cycle to hit
    abort_go = 1'b1;
    tick();
    abort_go = 1'b0;
    wait_lvl(hipri_abort, 1'b1, 5, n);
    // hold request on an idle bus, kept for a while
    hold_req = 1'b1;
    wait_lvl(bus_grant_out_n, 1'b0, 6, n);
    chk(n, 3);
    repeat (8)
    begin
      tick();
      chk({bus_grant_out_n, address_data_lines_oe, upper_data_lines_oe, address_strobe_oe,
           data_direction_oe, byte_enables_oe}, 6'h00);
    end
    hold_req = 1'b0;
    wait_lvl(bus_grant_out_n, 1'b1, 4, n);
    // hold request in mid-cycle must wait for the cycle to end
    cyc_kind = KIND_DATA;
    cyc_req = 1'b1;
    tick();
    {cyc_req, hold_req} = 2'b01;
    n = 0;
    while (cyc_done !== 1'b1 && n < 20)
    begin
      tick();
      n++;
      if (cyc_done !== 1'b1)
        chk(bus_grant_out_n, 1'b1);
    end
    wait_lvl(bus_grant_out_n, 1'b0, 3, n);
    hold_req = 1'b0;
    wait_lvl(bus_grant_out_n, 1'b1, 4, n);
    give_verdict();
  end
endmodule
